// *** core/gpb_map.svh ***
// Register map, field positions and reset values of the pin setup bank
// Functional notes
// - Pair {direction, enable}: 00 functional out, 10 tri-state, 01 GPIO out, 11 GPIO in.
// - Local level reaches pin only in GPIO output mode with remote drive off.
// - Remote drive set forces pin to output carrying the remote serializer value.
// - Second-port select moves pin 1 to 3 settings onto the second-port pins.
// - High pin uses bits 7:4, low pin 3:0; level, remote, direction, enable.
// - Reset: pin1 GPIO input, pin3 tri-state, pins 2, 5, 6 functional output.
`ifndef GPB_MAP_SVH
`define GPB_MAP_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define GPB_IDX_PAIR_A 8'h1e
`define GPB_IDX_PIN_C 8'h1f
`define GPB_IDX_PAIR_B 8'h20
`define GPB_IDX_CTRL 8'h24
`define GPB_IDX_STAT 8'h25

// ============================================================
// Reset values
`define GPB_RST_PAIR_A 8'h03
`define GPB_RST_PIN_C 8'h02
`define GPB_RST_PAIR_B 8'h00
`define GPB_RST_CTRL 1'h0

// ============================================================
// Field positions and masks
`define GPB_CTRL_SEL_BIT 0
`define GPB_PIN_C_MASK 8'h0f
`define GPB_RESP_OKAY 2'h0
`define GPB_RESP_SLVERR 2'h2

`endif

// *** core/gpb_pkg.sv ***
// Types shared by the pin setup bank
package gpb_pkg;

  // One pin's setup nibble, top bit first
  typedef struct packed {
    logic level;
    logic remote;
    logic dir;
    logic en;
  } gpb_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
  } gpb_pad_s;

  typedef enum {
    GPB_FUNC_OUT,
    GPB_TRISTATE,
    GPB_GPIO_OUT,
    GPB_GPIO_IN,
    GPB_REMOTE_OUT
  } gpb_mode_e;

endpackage

// *** core/gpb_top.sv ***
// Pin setup bank for pins 1, 2, 3, 5, 6 with AXI4-Lite register access
`timescale 1ns/100ps
`include "gpb_map.svh"

module gpb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] func_level,
  input wire logic [4:0] remote_level,
  input wire logic [4:0] pri_pad_in,
  input wire logic [2:0] sec_pad_in,
  output gpb_pkg::gpb_pad_s [4:0] pri_pad,
  output gpb_pkg::gpb_pad_s [2:0] sec_pad,
  output logic [4:0] gpio_in_level
);
  import gpb_pkg::*;

  // ============================================================
  // Register bus: write side
  logic aw_hold_q;
  logic [7:0] aw_idx_q;
  logic w_hold_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_hit;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_idx_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr[9:2];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_comb begin
    if (aw_idx_q == `GPB_IDX_PAIR_A) begin
      wr_hit = 1'b1;
    end else if (aw_idx_q == `GPB_IDX_PIN_C) begin
      wr_hit = 1'b1;
    end else if (aw_idx_q == `GPB_IDX_PAIR_B) begin
      wr_hit = 1'b1;
    end else if (aw_idx_q == `GPB_IDX_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_idx_q == `GPB_IDX_STAT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `GPB_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ============================================================
  // Setup registers
  logic [7:0] pair_a_q;
  logic [7:0] pin_c_q;
  logic [7:0] pair_b_q;
  logic sel_q;
  logic wr_lane;

  // Writes without byte lane 0 leave the 8-bit registers untouched
  assign wr_lane = wr_fire && w_lane0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_a_q <= `GPB_RST_PAIR_A;
    end else if (wr_lane && aw_idx_q == `GPB_IDX_PAIR_A) begin
      pair_a_q <= w_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_c_q <= `GPB_RST_PIN_C;
    end else if (wr_lane && aw_idx_q == `GPB_IDX_PIN_C) begin
      pin_c_q <= w_data_q & `GPB_PIN_C_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_b_q <= `GPB_RST_PAIR_B;
    end else if (wr_lane && aw_idx_q == `GPB_IDX_PAIR_B) begin
      pair_b_q <= w_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= `GPB_RST_CTRL;
    end else if (wr_lane && aw_idx_q == `GPB_IDX_CTRL) begin
      sel_q <= w_data_q[`GPB_CTRL_SEL_BIT];
    end
  end

  // ============================================================
  // Pad input synchronisers
  logic [4:0] pri_meta_q;
  logic [4:0] pri_sync_q;
  logic [2:0] sec_meta_q;
  logic [2:0] sec_sync_q;
  logic [4:0] in_pick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_meta_q <= 5'h00;
      pri_sync_q <= 5'h00;
      sec_meta_q <= 3'h0;
      sec_sync_q <= 3'h0;
    end else begin
      pri_meta_q <= pri_pad_in;
      pri_sync_q <= pri_meta_q;
      sec_meta_q <= sec_pad_in;
      sec_sync_q <= sec_meta_q;
    end
  end

  // ============================================================
  // Per-pin mode decode and pad drive
  gpb_cfg_s [4:0] cfg;
  gpb_pad_s [4:0] drive;
  gpb_pad_s [4:0] pri_pad_q;
  gpb_pad_s [2:0] sec_pad_q;
  logic [4:0] in_level_q;

  assign cfg[0] = pair_a_q[3:0];
  assign cfg[1] = pair_a_q[7:4];
  assign cfg[2] = pin_c_q[3:0];
  assign cfg[3] = pair_b_q[3:0];
  assign cfg[4] = pair_b_q[7:4];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      gpb_mode_e mode;

      always_comb begin
        if (cfg[gi].remote) begin
          mode = GPB_REMOTE_OUT;
        end else begin
          case ({cfg[gi].dir, cfg[gi].en})
            2'h0: mode = GPB_FUNC_OUT;
            2'h2: mode = GPB_TRISTATE;
            2'h1: mode = GPB_GPIO_OUT;
            default: mode = GPB_GPIO_IN;
          endcase
        end
      end

      // local level only in GPIO output
      always_comb begin
        case (mode)
          GPB_REMOTE_OUT: drive[gi] = '{out: remote_level[gi], oe: 1'b1};
          GPB_FUNC_OUT: drive[gi] = '{out: func_level[gi], oe: 1'b1};
          GPB_GPIO_OUT: drive[gi] = '{out: cfg[gi].level, oe: 1'b1};
          default: drive[gi] = '{out: 1'b0, oe: 1'b0};
        endcase
      end

      // Pins 1 to 3 sample whichever pad set is selected
      if (gi < 3) begin : g_dual
        assign in_pick[gi] = sel_q ? sec_sync_q[gi] : pri_sync_q[gi];
      end else begin : g_single
        assign in_pick[gi] = pri_sync_q[gi];
      end
    end
  endgenerate

  // second-port routing of pins 1 to 3
  // The unselected pad set is released so the two sets never fight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_pad_q <= '0;
      sec_pad_q <= '0;
    end else begin
      pri_pad_q[4:3] <= drive[4:3];
      pri_pad_q[2:0] <= sel_q ? '0 : drive[2:0];
      sec_pad_q <= sel_q ? drive[2:0] : '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_level_q <= 5'h00;
    end else begin
      in_level_q <= in_pick;
    end
  end

  assign pri_pad = pri_pad_q;
  assign sec_pad = sec_pad_q;
  assign gpio_in_level = in_level_q;

  // ============================================================
  // Register bus: read side
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic rd_hit;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;
  assign rd_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == `GPB_IDX_PAIR_A) begin
      rd_val = pair_a_q;
    end else if (rd_idx == `GPB_IDX_PIN_C) begin
      rd_val = pin_c_q;
    end else if (rd_idx == `GPB_IDX_PAIR_B) begin
      rd_val = pair_b_q;
    end else if (rd_idx == `GPB_IDX_CTRL) begin
      rd_val = {7'h00, sel_q};
    end else if (rd_idx == `GPB_IDX_STAT) begin
      rd_val = {3'h0, in_level_q};
    end else begin
      rd_val = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `GPB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// *** tb/gpb_asserts.sv ***
// Concurrent checks on the pin setup bank ports
`timescale 1ns/100ps
module gpb_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gpb_pkg::gpb_pad_s [4:0] pri_pad,
  input wire gpb_pkg::gpb_pad_s [2:0] sec_pad
);
  import gpb_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====
  // Bus and pad relations
  // Address and data are parked for one cycle before the register is written and answered
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_pads: assert property ($rose(aresetn) |-> pri_pad == '0 && sec_pad == '0)
    else $error("pads driven in reset");
  a_port_exclusive: assert property (
    !((pri_pad[0].oe && sec_pad[0].oe) || (pri_pad[1].oe && sec_pad[1].oe) || (pri_pad[2].oe && sec_pad[2].oe)))
    else $error("both pad sets driven");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_second_port: cover property (sec_pad[2].oe);
endmodule
bind gpb_top gpb_asserts gpb_asserts_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pri_pad, .sec_pad);

// *** tb/gpb_remote_model.sv ***
// Remote serializer model: forwards commanded pin values over the link
`timescale 1ns/100ps
module gpb_remote_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] send_level,
  output logic [4:0] remote_level
);
  // ====
  // Link delivery
  // remote value delivered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_level <= 5'h00;
    end else begin
      remote_level <= send_level;
    end
  end
endmodule

// *** tb/tb_gpio_pad_config_bank.sv ***
// Self-checking bench for the pin setup bank
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb_gpio_pad_config_bank;
  import gpb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] func_level = 5'h16, pri_pad_in = 5'h0b, send_level = 5'h04, remote_level, gpio_in_level;
  logic [2:0] sec_pad_in = 3'h5;
  gpb_pad_s [4:0] pri_pad;
  gpb_pad_s [2:0] sec_pad;
  int checks = 0, mismatches = 0;
  always #50 aclk = ~aclk;
  gpb_top gpb_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .func_level, .remote_level,
    .pri_pad_in, .sec_pad_in, .pri_pad, .sec_pad, .gpio_in_level);
  gpb_remote_model gpb_remote_model_inst (.aclk, .aresetn, .send_level, .remote_level);
  // ====
  // Bus tasks
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    mismatches++;
    final_report();
  end
  // ====
  // Tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(pri_pad[0].oe, 1'b0)
    `CHK(pri_pad[1], 2'b11)
    `CHK(pri_pad[2].oe, 1'b0)
    `CHK(pri_pad[3], 2'b01)
    rd(10'h078, 8'h03, 2'h0);
    rd(10'h07c, 8'h02, 2'h0);
    rd(10'h080, 8'h00, 2'h0);
    $display("test reset done");
    wr(10'h07c, 8'hfd, 4'hf, 2'h0);
    rd(10'h07c, 8'h0d, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(pri_pad[2], 2'b11)
    send_level <= 5'h00;
    repeat (3) @(posedge aclk);
    `CHK(pri_pad[2], 2'b01)
    $display("test remote done");
    for (int m = 0; m < 4; m++) begin
      wr(10'h080, {6'h26, m[1:0]}, 4'hf, 2'h0);
      repeat (2) @(posedge aclk);
      `CHK(pri_pad[4], 2'b11)
      `CHK(pri_pad[3].oe, !m[1])
      if (!m[1]) `CHK(pri_pad[3].out, m[0])
    end
    wr(10'h080, 8'h00, 4'he, 2'h0);
    rd(10'h080, 8'h9b, 2'h0);
    $display("test modes done");
    wr(10'h090, 8'h01, 4'hf, 2'h0);
    repeat (4) @(posedge aclk);
    `CHK(pri_pad[2].oe, 1'b0)
    `CHK(sec_pad[2], 2'b01)
    `CHK(sec_pad[1], 2'b11)
    rd(10'h094, {3'h0, pri_pad_in[4:3], sec_pad_in}, 2'h0);
    `CHK(gpio_in_level, {pri_pad_in[4:3], sec_pad_in})
    `CHK(pri_pad[1], 2'b00)
    `CHK(sec_pad[0], 2'b00)
    rd(10'h090, 8'h01, 2'h0);
    wr(10'h090, 8'h00, 4'hf, 2'h0);
    repeat (4) @(posedge aclk);
    `CHK(sec_pad[1], 2'b00)
    `CHK(pri_pad[1], 2'b11)
    `CHK(gpio_in_level, pri_pad_in)
    wr(10'h3fc, 8'h55, 4'hf, 2'h2);
    rd(10'h3fc, 8'h00, 2'h2);
    $display("test second port done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(pri_pad[2].oe, 1'b0)
    `CHK(pri_pad[4], 2'b11)
    `CHK(sec_pad[2], 2'b00)
    rd(10'h07c, 8'h02, 2'h0);
    rd(10'h080, 8'h00, 2'h0);
    rd(10'h090, 8'h00, 2'h0);
    $display("test mid reset done");
    final_report();
  end
endmodule
